// ==== wpm_pkg.sv ====
package wpm_pkg;

  // Sample and histogram geometry
  localparam int LVL_W         = 6;
  localparam int NUM_LVL       = 64;
  localparam int UPPER_FIRST   = 32;

  // Record and level-population limits
  localparam int MIN_REC_LEN   = 500;
  localparam int MIN_LVL_PCT   = 5;
  localparam int MIN_LVL_COUNT = MIN_REC_LEN * MIN_LVL_PCT / 100;

  // Threshold percentages of the base-to-top span
  localparam int PCT_FULL      = 100;
  localparam int THR_LO_PCT    = 10;
  localparam int THR_MID_PCT   = 50;
  localparam int THR_HI_PCT    = 90;

  // Result format
  localparam int RES_W         = 16;
  localparam logic [15:0] FREQ_SCALE = 16'hffff;

  // Reset values of the level trackers
  localparam logic [5:0] LVL_MAX_RST = 6'h00;
  localparam logic [5:0] LVL_MIN_RST = 6'h3f;

  typedef enum logic [2:0] {
    MEAS_PERIOD,
    MEAS_FREQ,
    MEAS_PK2PK,
    MEAS_PWIDTH,
    MEAS_RISE,
    MEAS_FALL
  } wpm_meas_type;

  // Nine states need four bits
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CLEAR,
    ST_HIST,
    ST_FIND,
    ST_THRESH,
    ST_SCAN,
    ST_EVAL,
    ST_DIV,
    ST_DONE
  } wpm_state_type;

endpackage : wpm_pkg

// ==== wpm_histogram.sv ====
`timescale 1ns/1ps
module wpm_histogram #(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      srst_i,
  // Accumulate
  input  wire logic                      clr_i,
  input  wire logic                      inc_i,
  input  wire logic [wpm_pkg::LVL_W-1:0] inc_lvl_i,
  // Peak search
  input  wire logic                      find_i,
  output logic                           busy_o,
  output logic [wpm_pkg::LVL_W-1:0]      top_lvl_o,
  output logic [CNT_W-1:0]               top_cnt_o,
  output logic [wpm_pkg::LVL_W-1:0]      base_lvl_o,
  output logic [CNT_W-1:0]               base_cnt_o
);
  import wpm_pkg::*;

  logic [CNT_W-1:0] bin_ff [NUM_LVL];
  logic [LVL_W-1:0] idx_ff;
  logic             busy_ff;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || clr_i)
    begin
      for (int i = 0; i < NUM_LVL; i++)
        bin_ff[i] <= '0;
    end
    else if (inc_i)
      bin_ff[inc_lvl_i] <= bin_ff[inc_lvl_i] + 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      busy_ff    <= 1'b0;
      idx_ff     <= '0;
      top_lvl_o  <= LVL_W'(UPPER_FIRST);
      top_cnt_o  <= '0;
      base_lvl_o <= LVL_W'(UPPER_FIRST - 1);
      base_cnt_o <= '0;
    end
    else if (find_i)
    begin
      busy_ff    <= 1'b1;
      idx_ff     <= '0;
      top_lvl_o  <= LVL_W'(UPPER_FIRST);
      top_cnt_o  <= '0;
      base_lvl_o <= LVL_W'(UPPER_FIRST - 1);
      base_cnt_o <= '0;
    end
    else if (busy_ff)
    begin
      if (idx_ff[LVL_W-1] && bin_ff[idx_ff] >= top_cnt_o)
      begin
        top_lvl_o <= idx_ff;
        top_cnt_o <= bin_ff[idx_ff];
      end
      if (!idx_ff[LVL_W-1] && bin_ff[idx_ff] > base_cnt_o)
      begin
        base_lvl_o <= idx_ff;
        base_cnt_o <= bin_ff[idx_ff];
      end
      idx_ff <= idx_ff + 1'b1;
      if (idx_ff == LVL_W'(NUM_LVL - 1))
        busy_ff <= 1'b0;
    end
  end

  assign busy_o = busy_ff;

endmodule : wpm_histogram

// ==== wpm_recip.sv ====
`timescale 1ns/1ps
module wpm_recip #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  // Operands
  input  wire logic         start_i,
  input  wire logic [W-1:0] num_i,
  input  wire logic [W-1:0] den_i,
  // Result
  output logic              busy_o,
  output logic [W-1:0]      quo_o
);
  import wpm_pkg::*;

  logic [W:0]         rem_ff;
  logic [W-1:0]       den_ff;
  logic [$clog2(W):0] cnt_ff;
  logic [W:0]         rem_sh;

  // Restoring division, one quotient bit per cycle
  assign rem_sh = {rem_ff[W-1:0], quo_o[W-1]};

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      busy_o <= 1'b0;
      rem_ff <= '0;
      den_ff <= '0;
      quo_o  <= '0;
      cnt_ff <= '0;
    end
    else if (start_i)
    begin
      busy_o <= 1'b1;
      rem_ff <= '0;
      den_ff <= den_i;
      quo_o  <= num_i;
      cnt_ff <= ($clog2(W) + 1)'(W);
    end
    else if (busy_o)
    begin
      if (rem_sh >= {1'b0, den_ff})
      begin
        rem_ff <= rem_sh - {1'b0, den_ff};
        quo_o  <= {quo_o[W-2:0], 1'b1};
      end
      else
      begin
        rem_ff <= rem_sh;
        quo_o  <= {quo_o[W-2:0], 1'b0};
      end
      cnt_ff <= cnt_ff - 1'b1;
      if (cnt_ff == ($clog2(W) + 1)'(1))
        busy_o <= 1'b0;
    end
  end

endmodule : wpm_recip

// ==== wpm_measure.sv ====
// Operation
// - Each sample is a 6-bit value, one of 64 levels.
// - A record holds at least 500 samples; shorter gives invalid.
// - Every sample of the record is read in both passes and counted once.
// - Histogram counts samples per level.
// - Top is the most populated level of the upper half.
// - Base is the most populated level of the lower half.
// - Below 25 samples, top and base fall back to max and min.
// - Top and base are found before thresholds or results.
// - Top is 100 and base 0 percent, except peak-to-peak.
// - Thresholds at 10, 50 and 90 percent of base-to-top span.
// - 10 and 90 percent thresholds serve only rise and fall times.
// - Period, frequency and width edges use the 50 percent threshold.
// - The leftmost usable part of the record is measured.
// - Period spans first two crossings of first edge's polarity.
// - Frequency is the reciprocal of that first-cycle interval.
// - Peak-to-peak is largest minus smallest sample.
// - Period and frequency need one complete cycle.
// - Pulse width needs both edges of the pulse.
// - Rise time needs a rising edge, fall time a falling edge.
`timescale 1ns/1ps
module wpm_measure #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       srst_i,
  // Request
  input  wire logic                       start_i,
  input  wire wpm_pkg::wpm_meas_type      meas_sel_i,
  input  wire logic [ADDR_W-1:0]          rec_len_i,
  // Sample memory
  output logic                            smp_rd_en_o,
  output logic [ADDR_W-1:0]               smp_addr_o,
  input  wire logic [wpm_pkg::LVL_W-1:0]  smp_data_i,
  // Result
  output logic                            busy_o,
  output logic                            done_o,
  output logic                            valid_o,
  output logic [wpm_pkg::RES_W-1:0]       result_o,
  output logic [wpm_pkg::LVL_W-1:0]       top_lvl_o,
  output logic [wpm_pkg::LVL_W-1:0]       base_lvl_o
);
  import wpm_pkg::*;

  if ((2 ** ADDR_W) - 1 < MIN_REC_LEN || ADDR_W > RES_W)
    $error("ADDR_W cannot hold a minimum record or exceeds result width");

  function automatic logic [LVL_W-1:0] thr_lvl(input logic [LVL_W-1:0] base,
                                               input logic [LVL_W-1:0] top,
                                               input logic [6:0]       pct);
    logic [13:0] prod;
    prod = 14'(top - base) * 14'(pct);
    return LVL_W'(base + LVL_W'(prod / 14'(PCT_FULL)));
  endfunction : thr_lvl

  wpm_state_type      st_ff;
  wpm_meas_type       meas_ff;
  logic [ADDR_W-1:0]  len_ff;
  logic               short_ff;
  logic [ADDR_W-1:0]  addr_ff;
  logic               issue_ff;
  logic               dv_ff;
  logic               dlast_ff;
  logic [ADDR_W-1:0]  didx_ff;
  logic [LVL_W-1:0]   max_ff;
  logic [LVL_W-1:0]   min_ff;
  logic [LVL_W-1:0]   top_ff;
  logic [LVL_W-1:0]   base_ff;
  logic [LVL_W-1:0]   prv_ff;
  logic               start_pass;
  logic               hbusy;
  logic               rbusy;
  logic               fb_w;
  logic [LVL_W-1:0]   h_top;
  logic [LVL_W-1:0]   h_base;
  logic [ADDR_W-1:0]  h_top_cnt;
  logic [ADDR_W-1:0]  h_base_cnt;
  logic [RES_W-1:0]   quo;
  logic [LVL_W-1:0]   th_lo;
  logic [LVL_W-1:0]   th_mid;
  logic [LVL_W-1:0]   th_hi;
  logic               scan_v;
  logic               up50;
  logic               dn50;
  logic               up10;
  logic               up90;
  logic               dn10;
  logic               dn90;
  // Edge tracking during the scan pass
  logic               e1_ff;
  logic               pol_ff;
  logic [ADDR_W-1:0]  t1_ff;
  logic               per_ok_ff;
  logic [ADDR_W-1:0]  per_ff;
  logic               r1_ff;
  logic [ADDR_W-1:0]  tr_ff;
  logic               pw_ok_ff;
  logic [ADDR_W-1:0]  pw_ff;
  logic               h10u_ff;
  logic [ADDR_W-1:0]  t10u_ff;
  logic               rise_ok_ff;
  logic [ADDR_W-1:0]  rise_ff;
  logic               h90d_ff;
  logic [ADDR_W-1:0]  t90d_ff;
  logic               fall_ok_ff;
  logic [ADDR_W-1:0]  fall_ff;
  logic [RES_W-1:0]   nxt_result;
  logic               nxt_valid;

  assign start_pass = (st_ff == ST_CLEAR) || (st_ff == ST_THRESH);

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      st_ff <= ST_IDLE;
    else
    begin
      unique case (st_ff)
        ST_IDLE:   if (start_i) st_ff <= (rec_len_i < ADDR_W'(MIN_REC_LEN)) ? ST_DONE : ST_CLEAR;
        ST_CLEAR:  st_ff <= ST_HIST;
        ST_HIST:   if (dlast_ff) st_ff <= ST_FIND;
        ST_FIND:   if (!hbusy) st_ff <= ST_THRESH;
        ST_THRESH: st_ff <= ST_SCAN;
        ST_SCAN:   if (dlast_ff) st_ff <= ST_EVAL;
        ST_EVAL:   st_ff <= (meas_ff == MEAS_FREQ && per_ok_ff) ? ST_DIV : ST_DONE;
        ST_DIV:    if (!rbusy) st_ff <= ST_DONE;
        ST_DONE:   st_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      meas_ff  <= MEAS_PERIOD;
      len_ff   <= '0;
      short_ff <= 1'b0;
    end
    else if (st_ff == ST_IDLE && start_i)
    begin
      meas_ff  <= meas_sel_i;
      len_ff   <= rec_len_i;
      short_ff <= rec_len_i < ADDR_W'(MIN_REC_LEN);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      addr_ff  <= '0;
      issue_ff <= 1'b0;
      dv_ff    <= 1'b0;
      dlast_ff <= 1'b0;
      didx_ff  <= '0;
    end
    else
    begin
      if (start_pass)
      begin
        addr_ff  <= '0;
        issue_ff <= 1'b1;
      end
      else if (issue_ff)
      begin
        addr_ff <= addr_ff + 1'b1;
        if (addr_ff == len_ff - 1'b1)
          issue_ff <= 1'b0;
      end
      dv_ff    <= issue_ff;
      dlast_ff <= issue_ff && (addr_ff == len_ff - 1'b1);
      didx_ff  <= addr_ff;
    end
  end

  assign smp_rd_en_o = issue_ff;
  assign smp_addr_o  = addr_ff;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || st_ff == ST_CLEAR)
    begin
      max_ff <= LVL_MAX_RST;
      min_ff <= LVL_MIN_RST;
    end
    else if (st_ff == ST_HIST && dv_ff)
    begin
      if (smp_data_i > max_ff)
        max_ff <= smp_data_i;
      if (smp_data_i < min_ff)
        min_ff <= smp_data_i;
    end
  end

  wpm_histogram #(
    .CNT_W (ADDR_W)
  ) u_hist (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .clr_i      (st_ff == ST_CLEAR),
    .inc_i      (st_ff == ST_HIST && dv_ff),
    .inc_lvl_i  (smp_data_i),
    .find_i     (st_ff == ST_HIST && dlast_ff),
    .busy_o     (hbusy),
    .top_lvl_o  (h_top),
    .top_cnt_o  (h_top_cnt),
    .base_lvl_o (h_base),
    .base_cnt_o (h_base_cnt)
  );

  assign fb_w = (h_top_cnt < ADDR_W'(MIN_LVL_COUNT)) || (h_base_cnt < ADDR_W'(MIN_LVL_COUNT));

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      top_ff  <= '0;
      base_ff <= '0;
    end
    else if (st_ff == ST_THRESH)
    begin
      top_ff  <= fb_w ? max_ff : h_top;
      base_ff <= fb_w ? min_ff : h_base;
    end
  end

  assign top_lvl_o  = top_ff;
  assign base_lvl_o = base_ff;

  assign th_lo  = thr_lvl(base_ff, top_ff, 7'(THR_LO_PCT));
  assign th_mid = thr_lvl(base_ff, top_ff, 7'(THR_MID_PCT));
  assign th_hi  = thr_lvl(base_ff, top_ff, 7'(THR_HI_PCT));

  assign scan_v = (st_ff == ST_SCAN) && dv_ff && (didx_ff != '0);
  assign up50   = scan_v && prv_ff < th_mid && smp_data_i >= th_mid;
  assign dn50   = scan_v && prv_ff >= th_mid && smp_data_i < th_mid;
  // outer levels for rise and fall only
  assign up10   = scan_v && prv_ff < th_lo && smp_data_i >= th_lo;
  assign up90   = scan_v && prv_ff < th_hi && smp_data_i >= th_hi;
  assign dn90   = scan_v && prv_ff >= th_hi && smp_data_i < th_hi;
  assign dn10   = scan_v && prv_ff >= th_lo && smp_data_i < th_lo;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      prv_ff <= '0;
    else if (dv_ff)
      prv_ff <= smp_data_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || st_ff == ST_THRESH)
    begin
      e1_ff      <= 1'b0;
      pol_ff     <= 1'b0;
      t1_ff      <= '0;
      per_ok_ff  <= 1'b0;
      per_ff     <= '0;
      r1_ff      <= 1'b0;
      tr_ff      <= '0;
      pw_ok_ff   <= 1'b0;
      pw_ff      <= '0;
      h10u_ff    <= 1'b0;
      t10u_ff    <= '0;
      rise_ok_ff <= 1'b0;
      rise_ff    <= '0;
      h90d_ff    <= 1'b0;
      t90d_ff    <= '0;
      fall_ok_ff <= 1'b0;
      fall_ff    <= '0;
    end
    else
    begin
      if (!e1_ff && (up50 || dn50))
      begin
        e1_ff  <= 1'b1;
        pol_ff <= up50;
        t1_ff  <= didx_ff;
      end
      else if (e1_ff && !per_ok_ff && ((pol_ff && up50) || (!pol_ff && dn50)))
      begin
        per_ok_ff <= 1'b1;
        per_ff    <= didx_ff - t1_ff;
      end
      if (up50 && !r1_ff)
      begin
        r1_ff <= 1'b1;
        tr_ff <= didx_ff;
      end
      if (dn50 && r1_ff && !pw_ok_ff)
      begin
        pw_ok_ff <= 1'b1;
        pw_ff    <= didx_ff - tr_ff;
      end
      if (up10)
      begin
        h10u_ff <= 1'b1;
        t10u_ff <= didx_ff;
      end
      if (up90 && (up10 || h10u_ff) && !rise_ok_ff)
      begin
        rise_ok_ff <= 1'b1;
        rise_ff    <= up10 ? '0 : didx_ff - t10u_ff;
      end
      if (dn90)
      begin
        h90d_ff <= 1'b1;
        t90d_ff <= didx_ff;
      end
      if (dn10 && (dn90 || h90d_ff) && !fall_ok_ff)
      begin
        fall_ok_ff <= 1'b1;
        fall_ff    <= dn90 ? '0 : didx_ff - t90d_ff;
      end
    end
  end

  wpm_recip #(
    .W (RES_W)
  ) u_recip (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .start_i    (st_ff == ST_EVAL && meas_ff == MEAS_FREQ && per_ok_ff),
    .num_i      (FREQ_SCALE),
    .den_i      (RES_W'(per_ff)),
    .busy_o     (rbusy),
    .quo_o      (quo)
  );

  always_comb
  begin
    nxt_result = '0;
    nxt_valid  = 1'b0;
    unique case (meas_ff)
      MEAS_PERIOD: begin nxt_valid = per_ok_ff;  nxt_result = RES_W'(per_ff);  end
      MEAS_FREQ:   begin nxt_valid = per_ok_ff;  nxt_result = quo;             end
      MEAS_PK2PK:  begin nxt_valid = 1'b1;       nxt_result = RES_W'(max_ff - min_ff); end
      MEAS_PWIDTH: begin nxt_valid = pw_ok_ff;   nxt_result = RES_W'(pw_ff);   end
      MEAS_RISE:   begin nxt_valid = rise_ok_ff; nxt_result = RES_W'(rise_ff); end
      MEAS_FALL:   begin nxt_valid = fall_ok_ff; nxt_result = RES_W'(fall_ff); end
      default:     begin nxt_valid = 1'b0;       nxt_result = '0;              end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      done_o   <= 1'b0;
      valid_o  <= 1'b0;
      result_o <= '0;
    end
    else
    begin
      done_o <= (st_ff == ST_DONE);
      if (st_ff == ST_DONE)
      begin
        valid_o  <= nxt_valid && !short_ff;
        result_o <= (nxt_valid && !short_ff) ? nxt_result : '0;
      end
    end
  end

  assign busy_o = (st_ff != ST_IDLE);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_short_rec_invalid: assert property (
    (st_ff == ST_IDLE && start_i && rec_len_i < ADDR_W'(MIN_REC_LEN)) |-> ##2 (done_o && !valid_o))
    else $error("short record not flagged invalid");
  a_read_in_range: assert property (
    smp_rd_en_o |-> smp_addr_o < len_ff)
    else $error("sample read beyond record");
  a_top_base_halves: assert property (
    (st_ff == ST_THRESH && !fb_w) |=> (top_ff[LVL_W-1] && !base_ff[LVL_W-1]))
    else $error("top or base outside its half");
  a_fallback_extremes: assert property (
    (st_ff == ST_THRESH && fb_w) |=> (top_ff == max_ff && base_ff == min_ff))
    else $error("fallback did not take record extremes");
  a_find_before_scan: assert property (
    (st_ff == ST_SCAN && $past(st_ff != ST_SCAN)) |-> $past(st_ff == ST_THRESH))
    else $error("scan entered without top and base");
  a_thr_ordered: assert property (
    (st_ff == ST_SCAN) |-> (base_ff <= th_lo && th_lo <= th_mid && th_mid <= th_hi && th_hi <= top_ff))
    else $error("thresholds out of order");
  a_period_interval: assert property (
    (e1_ff && !per_ok_ff && ((pol_ff && up50) || (!pol_ff && dn50)))
      |=> (per_ok_ff && per_ff == $past(didx_ff) - $past(t1_ff)))
    else $error("period interval wrong");
  a_pk2pk_value: assert property (
    (done_o && meas_ff == MEAS_PK2PK && valid_o) |-> result_o == RES_W'(max_ff - min_ff))
    else $error("peak-to-peak value wrong");
  a_cycle_needed: assert property (
    (done_o && (meas_ff == MEAS_PERIOD || meas_ff == MEAS_FREQ)) |-> (valid_o == (per_ok_ff && !short_ff)))
    else $error("period validity does not follow full cycle");
  a_invalid_zero: assert property (
    (done_o && !valid_o) |-> (result_o == '0))
    else $error("invalid result not zero");

endmodule : wpm_measure

// ==== wpm_sample_mem.sv ====
`timescale 1ns/1ps
module wpm_sample_mem #(
  parameter int ADDR_W = 10
) (
  // Clock
  input  wire logic                      core_clk_i,
  // Read port
  input  wire logic                      rd_en_i,
  input  wire logic [ADDR_W-1:0]         addr_i,
  output logic [wpm_pkg::LVL_W-1:0]      data_o
);
  import wpm_pkg::*;

  logic [LVL_W-1:0] mem [0:(1<<ADDR_W)-1];

  initial data_o = 6'h15;

  always @(posedge core_clk_i)
  begin
    if (rd_en_i)
      data_o <= mem[addr_i];
    else
      data_o <= ~data_o;  // Stale data must not look valid
  end
endmodule : wpm_sample_mem

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import wpm_pkg::*;

  typedef struct packed {
    logic        valid;
    logic        chk;
    logic [5:0]  top;
    logic [5:0]  base;
    logic [15:0] res;
  } wpm_tb_exp_type;

  logic                core_clk_i;
  logic                srst_i;
  logic                start_i;
  wpm_meas_type        meas_sel_i;
  logic [9:0]          rec_len_i;
  logic                smp_rd_en_o;
  logic [9:0]          smp_addr_o;
  logic [LVL_W-1:0]    smp_data_i;
  logic                busy_o;
  logic                done_o;
  logic                valid_o;
  logic [RES_W-1:0]    result_o;
  logic [LVL_W-1:0]    top_lvl_o;
  logic [LVL_W-1:0]    base_lvl_o;
  int                  checks = 0;
  int                  mismatches = 0;
  int                  len;
  logic [31:0]         seed = 32'h537e;
  wpm_tb_exp_type      exp_q[$];
  wpm_tb_exp_type      e;

  wpm_measure u_wpm_measure (
    .core_clk_i (core_clk_i), .srst_i (srst_i), .start_i (start_i),
    .meas_sel_i (meas_sel_i), .rec_len_i (rec_len_i), .smp_rd_en_o (smp_rd_en_o),
    .smp_addr_o (smp_addr_o), .smp_data_i (smp_data_i), .busy_o (busy_o),
    .done_o (done_o), .valid_o (valid_o), .result_o (result_o),
    .top_lvl_o (top_lvl_o), .base_lvl_o (base_lvl_o));

  wpm_sample_mem u_wpm_sample_mem (
    .core_clk_i (core_clk_i), .rd_en_i (smp_rd_en_o), .addr_i (smp_addr_o),
    .data_o (smp_data_i));

  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  function automatic int rnd(input int n);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed[15:0]) % n;
  endfunction : rnd

  function automatic int lvl(input int i);
    return int'(u_wpm_sample_mem.mem[i]);
  endfunction : lvl

  function automatic bit crossed(input int th, input bit up, input int i);
    return up ? (lvl(i-1) < th && lvl(i) >= th) : (lvl(i-1) >= th && lvl(i) < th);
  endfunction : crossed

  function automatic int xing(input int th, input bit up, input int from, input int n);
    for (int i = from; i < n; i++)
      if (crossed(th, up, i)) return i;
    return -1;
  endfunction : xing

  function automatic int lastx(input int th, input bit up, input int to);
    for (int i = to; i >= 1; i--)
      if (crossed(th, up, i)) return i;
    return -1;
  endfunction : lastx

  // Leftmost usable edge: first far crossing with a near crossing before it
  function automatic int first_pair(input int ta, input int tb, input bit up, input int n,
                                    output int b);
    int a;
    a = -1;
    b = xing(tb, up, 1, n);
    while (b >= 0 && a < 0)
    begin
      a = lastx(ta, up, b);
      if (a < 0) b = xing(tb, up, b + 1, n);
    end
    return a;
  endfunction : first_pair

  // Trapezoid: flat low, ramp of k, flat high, ramp of k
  task automatic fill(input int lo, input int hi, input int p, input int k, input int ph);
    int t;
    int h;
    h = p / 2;
    for (int i = 0; i < 1024; i++)
    begin
      t = (i + ph) % p;
      if (t < h - k) t = lo;
      else if (t < h) t = lo + (hi - lo) * (t - (h - k) + 1) / (k + 1);
      else if (t < p - k) t = hi;
      else t = hi - (hi - lo) * (t - (p - k) + 1) / (k + 1);
      u_wpm_sample_mem.mem[i] = 6'(t);
    end
  endtask : fill

  function automatic wpm_tb_exp_type model(input wpm_meas_type sel, input int n);
    wpm_tb_exp_type x;
    int cnt [0:63];
    int top, base, tc, bc, mx, mn, a, b, t10, t50, t90;
    x = '0;
    x.chk = (n >= MIN_REC_LEN);
    if (!x.chk) return x;
    mx = 0;
    mn = 63;
    tc = -1;
    bc = -1;
    foreach (cnt[l]) cnt[l] = 0;
    for (int i = 0; i < n; i++)
    begin
      cnt[lvl(i)]++;
      mx = (lvl(i) > mx) ? lvl(i) : mx;
      mn = (lvl(i) < mn) ? lvl(i) : mn;
    end
    for (int l = NUM_LVL - 1; l >= UPPER_FIRST; l--)
      if (cnt[l] > tc) {tc, top} = {l == l ? cnt[l] : 0, l};
    for (int l = 0; l < UPPER_FIRST; l++)
      if (cnt[l] > bc) {bc, base} = {cnt[l], l};
    if (tc < MIN_LVL_COUNT || bc < MIN_LVL_COUNT) {top, base} = {mx, mn};
    x.top = 6'(top);
    x.base = 6'(base);
    t10 = base + (top - base) * THR_LO_PCT / PCT_FULL;
    t50 = base + (top - base) * THR_MID_PCT / PCT_FULL;
    t90 = base + (top - base) * THR_HI_PCT / PCT_FULL;
    a = xing(t50, 1'b1, 1, n);
    b = xing(t50, 1'b0, 1, n);
    case (sel)
      MEAS_PK2PK: {a, b} = {mn, mx};
      MEAS_PWIDTH: b = (a < 0) ? -1 : xing(t50, 1'b0, a + 1, n);
      MEAS_RISE: a = first_pair(t10, t90, 1'b1, n, b);
      MEAS_FALL: a = first_pair(t90, t10, 1'b0, n, b);
      default:
      begin
        if (b >= 0 && (a < 0 || b < a)) a = b;
        b = (a < 0) ? -1 : xing(t50, crossed(t50, 1'b1, a), a + 1, n);
      end
    endcase
    x.valid = (a >= 0 && b >= 0);
    if (x.valid) x.res = (sel == MEAS_FREQ) ? 16'(int'(FREQ_SCALE) / (b - a)) : 16'(b - a);
    return x;
  endfunction : model

  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    checks++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask : check

  // Start stays high while busy, so a refused request is also exercised
  task automatic run(input wpm_meas_type sel, input int n);
    exp_q.push_back(model(sel, n));
    start_i = 1'b1;
    meas_sel_i = sel;
    rec_len_i = 10'(n);
    for (int c = 0; c < 4000 && busy_o !== 1'b0; c++)
    begin
      @(posedge core_clk_i);
      #1;
    end
    @(posedge core_clk_i);
    #1;
  endtask : run

  task automatic drain();
    start_i = 1'b0;
    for (int c = 0; c < 5000 && exp_q.size() != 0; c++)
      @(posedge core_clk_i);
    #1;
  endtask : drain

  always @(negedge core_clk_i)
  begin
    if (done_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check({15'h0, done_o}, 16'h0000, "done without request");
      else
      begin
        e = exp_q.pop_front();
        check({15'h0, valid_o}, {15'h0, e.valid}, "valid");
        check(result_o, e.res, "result");
        check({15'h0, busy_o}, 16'h0000, "busy at done");
        if (e.chk) check({10'h0, top_lvl_o}, {10'h0, e.top}, "top");
        if (e.chk) check({10'h0, base_lvl_o}, {10'h0, e.base}, "base");
      end
    end
  end

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (80000) @(posedge core_clk_i);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    srst_i = 1'b1;
    start_i = 1'b0;
    meas_sel_i = MEAS_PERIOD;
    rec_len_i = 10'h000;
    fill(10, 50, 40, 2, 0);
    repeat (5) @(posedge core_clk_i);
    #1;
    srst_i = 1'b0;
    for (int w = 0; w < 7; w++)
    begin
      len = (w >= 4) ? 500 : 500 + rnd(400);
      case (w)
        4: fill(1, 62, 124, 62, 0);  // Triangle: no level dense enough
        5: fill(45, 45, 2, 0, 0);  // Flat: no edge at all
        6: fill(3, 58, 2048, 3, 700);  // One rising step only
        default: fill(rnd(20), 40 + rnd(24), 20 + 2 * rnd(60), rnd(5), rnd(100));
      endcase
      for (int m = 0; m < 6; m++)
        run(wpm_meas_type'(m), len);
      drain();
    end
    run(MEAS_PK2PK, 499);
    run(MEAS_PERIOD, 499);
    drain();
    stop_test();
  end
endmodule : testbench
